// ==== logic/wrmsg_defines.svh ====
// Field positions, register offsets and reset values for the write message decoder
`ifndef WRMSG_DEFINES_SVH
`define WRMSG_DEFINES_SVH

// Descriptor fields
`define LAYOUT_MSB 11
`define LAYOUT_LSB 10
`define OFS_MSB 9
`define OFS_LSB 4
`define OPC_MSB 3
`define OPC_LSB 0

// Layout codes
`define LAYOUT_DIRECT 2'h0
`define LAYOUT_INTERLEAVED 2'h1
`define LAYOUT_TRANSPOSED 2'h2
`define LAYOUT_RESERVED 2'h3

// Operation codes
`define OPC_WRITE 4'h0
`define OPC_SYNC 4'h1

// Header dwords 0 and 1: entry tag and result handle
`define TAG_MSB 31
`define TAG_LSB 16
`define HND_MSB 15
`define HND_LSB 0

// Header dword 5 and dword 2 fields
`define THREAD_TAG_MSB 7
`define THREAD_TAG_LSB 0
`define SO_INC_MSB 26
`define SO_INC_LSB 16
`define CLIP_BIT 7
`define PTYPE_MSB 6
`define PTYPE_LSB 2
`define FIRST_BIT 1
`define LAST_BIT 0

// Register byte offsets
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_COUNT 12'h008

// Control bits and reset value
`define CTRL_NEW_GEN 0
`define CTRL_CLIP_REV 1
`define CTRL_CLIP_EN 2
`define CTRL_RESET 3'h0

// Status bits
`define STAT_ERR 0
`define STAT_CAUSE_LSB 4
`define STAT_CAUSE_MSB 6

`endif

// ==== logic/wrmsg_pkg.sv ====
// Types shared by the write message decoder files
package wrmsg_pkg;
    // Why a message was refused
    typedef enum logic [2:0] {
        CAUSE_NONE,
        CAUSE_OPCODE,
        CAUSE_LAYOUT,
        CAUSE_COMBO,
        CAUSE_OFFSET
    } err_cause_t;
endpackage

// ==== logic/wrmsg_apb_regs.sv ====
// APB register file: control bits, sticky error status and message count
`timescale 1ns/1ps
`include "wrmsg_defines.svh"
module wrmsg_apb_regs
    import wrmsg_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Block side
    input wire logic err_event,
    input wire err_cause_t err_cause,
    input wire logic msg_event,
    output logic [2:0] ctrl_q
);
    logic err_q;
    err_cause_t cause_q;
    logic [15:0] count_q;
    logic access;
    logic mapped;

    // Zero wait states; every access finishes in its first access cycle
    assign access = psel && penable;
    assign pready = 1'h1;
    assign mapped = (paddr == `REG_CTRL) || (paddr == `REG_STATUS) || (paddr == `REG_COUNT);
    assign pslverr = access && !mapped;

    // Control register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_q <= `CTRL_RESET;
        end else if (access && pwrite && paddr == `REG_CTRL) begin
            ctrl_q <= pwdata[2:0];
        end
    end

    // Sticky error flag; a new error wins over a write-one-to-clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            err_q <= 1'h0;
            cause_q <= CAUSE_NONE;
        end else if (err_event) begin
            err_q <= 1'h1;
            cause_q <= err_cause;
        end else if (access && pwrite && paddr == `REG_STATUS && pwdata[`STAT_ERR]) begin
            err_q <= 1'h0;
        end
    end

    // Accepted message count, wraps; a write clears it unless a message is counted in the same cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_q <= 16'h0000;
        end else if (msg_event) begin
            count_q <= count_q + 16'h0001;
        end else if (access && pwrite && paddr == `REG_COUNT) begin
            count_q <= 16'h0000;
        end
    end

    // Read mux; unmapped reads return zero
    always_comb begin
        prdata = 32'h0000_0000;
        unique case (paddr)
            `REG_CTRL: prdata[2:0] = ctrl_q;
            `REG_STATUS: begin
                prdata[`STAT_ERR] = err_q;
                prdata[`STAT_CAUSE_MSB:`STAT_CAUSE_LSB] = cause_q;
            end
            `REG_COUNT: prdata[15:0] = count_q;
            default: prdata = 32'h0000_0000;
        endcase
    end
endmodule

// ==== logic/return_buffer_write_msg_decode.sv ====
// Decoder and checker for return buffer write messages from execution threads
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "wrmsg_defines.svh"
module return_buffer_write_msg_decode
    import wrmsg_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Incoming message
    input wire logic msg_valid,
    output logic msg_ready,
    input wire logic [11:0] desc_ctl,
    input wire logic desc_complete,
    input wire logic desc_used,
    input wire logic desc_allocate,
    input wire logic desc_end_of_thread,
    input wire logic [31:0] hdr_dw0,
    input wire logic [31:0] hdr_dw1,
    input wire logic [31:0] hdr_dw2,
    input wire logic [31:0] hdr_dw5,
    // Decoded message, one cycle after acceptance
    output logic out_valid_q,
    output logic buffer_write_op_q,
    output logic fixed_function_sync_op_q,
    output logic [1:0] layout_q,
    output logic [5:0] offset_ch0_q,
    output logic [5:0] offset_ch1_q,
    output logic ch1_valid_q,
    // Entry and thread actions
    output logic partial_write_q,
    output logic release_entry_q,
    output logic finished_output_q,
    output logic grant_alloc_q,
    output logic terminate_thread_q,
    // Header fields
    output logic [7:0] fixed_unit_thread_tag_q,
    output logic [10:0] stream_out_prims_written_stat_q,
    output logic clipper_invocation_stat_q,
    output logic [4:0] vertex0_primitive_type_q,
    output logic vertex0_first_flag_q,
    output logic vertex0_last_flag_q,
    output logic [15:0] entry_tag_ch0_q,
    output logic [15:0] result_handle_ch0_q,
    output logic [15:0] entry_tag_ch1_q,
    output logic [15:0] result_handle_ch1_q,
    // Error report
    output logic error_q,
    output err_cause_t error_cause_q
);
    logic accept;
    logic [1:0] layout_in;
    logic [5:0] offset_in;
    logic [3:0] opcode_in;
    logic [7:0] thread_tag_in;
    logic is_write;
    logic is_sync;
    logic is_interleaved;
    logic err_d;
    err_cause_t cause_d;
    logic [2:0] ctrl;

    // Decoding is a single registered stage, so there is never a reason to stall
    assign msg_ready = 1'h1;
    assign accept = msg_valid && msg_ready;

    // Descriptor fields
    assign layout_in = desc_ctl[`LAYOUT_MSB:`LAYOUT_LSB];
    assign offset_in = desc_ctl[`OFS_MSB:`OFS_LSB];
    assign opcode_in = desc_ctl[`OPC_MSB:`OPC_LSB];
    assign thread_tag_in = hdr_dw5[`THREAD_TAG_MSB:`THREAD_TAG_LSB];
    assign is_write = (opcode_in == `OPC_WRITE);
    assign is_sync = (opcode_in == `OPC_SYNC);
    assign is_interleaved = (layout_in == `LAYOUT_INTERLEAVED);

    // Message checks, highest priority first; only one cause is reported
    always_comb begin
        err_d = 1'h1;
        cause_d = CAUSE_NONE;
        if (!is_write && !is_sync) begin
            cause_d = CAUSE_OPCODE;
        end else if (is_write && layout_in == `LAYOUT_RESERVED) begin
            cause_d = CAUSE_LAYOUT;
        end else if (desc_allocate && desc_end_of_thread) begin
            cause_d = CAUSE_COMBO;
        end else if (is_write && layout_in == `LAYOUT_TRANSPOSED && offset_in[0]) begin
            cause_d = CAUSE_OFFSET;
        end else begin
            err_d = 1'h0;
        end
    end

    // Acceptance strobe and error report
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            out_valid_q <= 1'h0;
            error_q <= 1'h0;
            error_cause_q <= CAUSE_NONE;
        end else begin
            out_valid_q <= accept;
            error_q <= accept && err_d;
            error_cause_q <= accept ? cause_d : CAUSE_NONE;
        end
    end

    // Operation and layout; a refused message carries no operation
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            buffer_write_op_q <= 1'h0;
            fixed_function_sync_op_q <= 1'h0;
            layout_q <= `LAYOUT_DIRECT;
            offset_ch0_q <= 6'h00;
            offset_ch1_q <= 6'h00;
            ch1_valid_q <= 1'h0;
        end else if (accept) begin
            buffer_write_op_q <= is_write && !err_d;
            fixed_function_sync_op_q <= is_sync && !err_d;
            layout_q <= layout_in;
            offset_ch0_q <= offset_in;
            // Same granule offset for both de-interleaved streams
            offset_ch1_q <= is_interleaved ? offset_in : 6'h00;
            ch1_valid_q <= is_interleaved && is_write && !err_d;
        end
    end

    // Entry and thread actions; an illegal combination must not free anything
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            partial_write_q <= 1'h0;
            release_entry_q <= 1'h0;
            finished_output_q <= 1'h0;
            grant_alloc_q <= 1'h0;
            terminate_thread_q <= 1'h0;
        end else begin
            // Used bit is don't-care while complete is clear
            partial_write_q <= accept && !err_d && !desc_complete
                && !desc_allocate && !desc_end_of_thread;
            release_entry_q <= accept && !err_d && desc_complete && !desc_used;
            finished_output_q <= accept && !err_d && desc_complete && desc_used;
            // Without complete, the thread vouches for its earlier entries
            grant_alloc_q <= accept && !err_d && desc_allocate
                && !desc_end_of_thread;
            terminate_thread_q <= accept && !err_d && desc_end_of_thread
                && !desc_allocate;
        end
    end

    // Header fields; the thread tag is only acted on with a termination
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fixed_unit_thread_tag_q <= 8'h00;
            stream_out_prims_written_stat_q <= 11'h000;
            clipper_invocation_stat_q <= 1'h0;
            vertex0_primitive_type_q <= 5'h00;
            vertex0_first_flag_q <= 1'h0;
            vertex0_last_flag_q <= 1'h0;
        end else if (accept) begin
            fixed_unit_thread_tag_q <= thread_tag_in;
            // Older generations count these elsewhere, so the field is dropped
            stream_out_prims_written_stat_q <= (ctrl[`CTRL_NEW_GEN] && !err_d)
                ? hdr_dw2[`SO_INC_MSB:`SO_INC_LSB] : 11'h000;
            clipper_invocation_stat_q <= ctrl[`CTRL_CLIP_REV] && ctrl[`CTRL_CLIP_EN]
                && hdr_dw2[`CLIP_BIT] && !err_d;
            // Passed through as sent; the sender zeroes them for other targets
            vertex0_primitive_type_q <= hdr_dw2[`PTYPE_MSB:`PTYPE_LSB];
            vertex0_first_flag_q <= hdr_dw2[`FIRST_BIT];
            vertex0_last_flag_q <= hdr_dw2[`LAST_BIT];
        end
    end

    // Channel tags and handles; channel 1 reads as zero unless interleaved
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            entry_tag_ch0_q <= 16'h0000;
            result_handle_ch0_q <= 16'h0000;
            entry_tag_ch1_q <= 16'h0000;
            result_handle_ch1_q <= 16'h0000;
        end else if (accept) begin
            entry_tag_ch0_q <= hdr_dw0[`TAG_MSB:`TAG_LSB];
            result_handle_ch0_q <= hdr_dw0[`HND_MSB:`HND_LSB];
            entry_tag_ch1_q <= is_interleaved ? hdr_dw1[`TAG_MSB:`TAG_LSB] : 16'h0000;
            result_handle_ch1_q <= is_interleaved
                ? hdr_dw1[`HND_MSB:`HND_LSB] : 16'h0000;
        end
    end

    // Software view: generation options, sticky error, message count
    wrmsg_apb_regs regs (
        .mclk(mclk),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .err_event(error_q),
        .err_cause(error_cause_q),
        .msg_event(out_valid_q),
        .ctrl_q(ctrl)
    );

    // Checks on the decoded stream
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    layout_reserved_a: assert property (
        accept && is_write && layout_in == `LAYOUT_RESERVED
        |=> error_q && error_cause_q == CAUSE_LAYOUT && !buffer_write_op_q)
        else $error("reserved layout not refused");

    offset_pass_a: assert property (
        accept |=> offset_ch0_q == $past(offset_in))
        else $error("offset not carried");

    interleave_offset_a: assert property (
        accept && is_write && is_interleaved && !err_d
        |=> ch1_valid_q && offset_ch1_q == offset_ch0_q)
        else $error("interleaved offsets differ");

    transpose_lsb_a: assert property (
        accept && is_write && layout_in == `LAYOUT_TRANSPOSED && offset_in[0]
        && !desc_allocate |=> error_q && error_cause_q == CAUSE_OFFSET)
        else $error("odd transposed offset accepted");

    opcode_decode_a: assert property (
        accept && is_sync && !err_d |=> fixed_function_sync_op_q && !buffer_write_op_q)
        else $error("sync opcode misdecoded");

    partial_write_a: assert property (
        accept && is_write && !err_d && !desc_complete && !desc_allocate
        && !desc_end_of_thread
        |=> partial_write_q && !release_entry_q && !grant_alloc_q && !terminate_thread_q)
        else $error("partial write took an action");

    alloc_end_a: assert property (
        accept && desc_allocate && desc_end_of_thread
        |=> error_q && !grant_alloc_q && !terminate_thread_q ##1 !error_q || out_valid_q)
        else $error("allocate with end of thread acted on");

    release_grant_a: assert property (
        accept && !err_d && desc_complete && !desc_used && desc_allocate
        |=> release_entry_q && grant_alloc_q && !finished_output_q)
        else $error("release with allocation wrong");

    finish_end_a: assert property (
        accept && !err_d && desc_complete && desc_used && desc_end_of_thread
        |=> finished_output_q && terminate_thread_q && !grant_alloc_q)
        else $error("finish with termination wrong");

    thread_tag_a: assert property (
        accept |=> fixed_unit_thread_tag_q == $past(thread_tag_in))
        else $error("thread tag not carried");

    stat_gen_a: assert property (
        out_valid_q && stream_out_prims_written_stat_q != 11'h000
        |-> $past(ctrl[`CTRL_NEW_GEN]) && !error_q)
        else $error("primitive count on old generation");

    clip_count_a: assert property (
        out_valid_q && clipper_invocation_stat_q
        |-> $past(ctrl[`CTRL_CLIP_EN]) && $past(ctrl[`CTRL_CLIP_REV]) && !error_q)
        else $error("clipper count while disabled");

    ch1_ignore_a: assert property (
        accept && !is_interleaved |=> entry_tag_ch1_q == 16'h0000 && !ch1_valid_q)
        else $error("channel 1 used outside interleaving");

    // Main scenarios
    cover_interleaved_c: cover property (accept && is_interleaved && !err_d ##1 ch1_valid_q);
    cover_sync_c: cover property (accept && is_sync ##1 fixed_function_sync_op_q);
    cover_terminate_c: cover property (accept ##1 terminate_thread_q && finished_output_q);
    cover_error_c: cover property (accept && err_d ##1 error_q ##1 out_valid_q);
endmodule

// ==== verif/thread_sender.sv ====
// Issuing thread model: presents one write message for a single taking edge
`timescale 1ns/1ps
module thread_sender (
    // Clock
    input wire logic mclk,
    // Message towards the decoder
    output logic msg_valid,
    output logic [11:0] desc_ctl,
    output logic [3:0] ctl_bits,
    output logic [31:0] hdr_dw0,
    output logic [31:0] hdr_dw1,
    output logic [31:0] hdr_dw2,
    output logic [31:0] hdr_dw5
);
    logic [143:0] body;
    // Quiet until the first message
    initial begin
        msg_valid = 1'b0;
        body = '0;
    end
    assign {desc_ctl, ctl_bits, hdr_dw0, hdr_dw1, hdr_dw2, hdr_dw5} = body;
    // Callers send legal messages unless a scenario means to be refused
    task automatic send(input logic [143:0] m);
        @(posedge mclk);
        msg_valid <= 1'b1;
        body <= m;
        @(posedge mclk);
        msg_valid <= 1'b0;
        body <= ~m; // Idle fields must not echo the last message
    endtask
endmodule

// ==== verif/return_buffer_write_msg_decode_tb.sv ====
// Self-checking bench for the write message decoder
`timescale 1ns/1ps
module return_buffer_write_msg_decode_tb
    import wrmsg_pkg::*;
;
    logic mclk, rst, psel, penable, pwrite, pready, pslverr, msg_valid, msg_ready, perr;
    logic [11:0] paddr, desc_ctl;
    logic [31:0] pwdata, prdata, hdr_dw0, hdr_dw1, hdr_dw2, hdr_dw5, rd;
    logic [3:0] ctl_bits;
    logic [2:0] ctrl_sh;
    logic out_valid_q, buffer_write_op_q, fixed_function_sync_op_q, ch1_valid_q;
    logic partial_write_q, release_entry_q, finished_output_q, grant_alloc_q;
    logic terminate_thread_q, error_q, clipper_invocation_stat_q;
    logic vertex0_first_flag_q, vertex0_last_flag_q;
    logic [1:0] layout_q;
    logic [5:0] offset_ch0_q, offset_ch1_q;
    logic [7:0] fixed_unit_thread_tag_q;
    logic [10:0] stream_out_prims_written_stat_q;
    logic [4:0] vertex0_primitive_type_q;
    logic [15:0] entry_tag_ch0_q, result_handle_ch0_q, entry_tag_ch1_q, result_handle_ch1_q;
    err_cause_t error_cause_q;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    int msg_n = 0;

    return_buffer_write_msg_decode uut (
        .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .msg_valid, .msg_ready, .desc_ctl, .desc_complete(ctl_bits[3]),
        .desc_used(ctl_bits[2]), .desc_allocate(ctl_bits[1]),
        .desc_end_of_thread(ctl_bits[0]), .hdr_dw0, .hdr_dw1, .hdr_dw2, .hdr_dw5,
        .out_valid_q, .buffer_write_op_q, .fixed_function_sync_op_q, .layout_q,
        .offset_ch0_q, .offset_ch1_q, .ch1_valid_q, .partial_write_q, .release_entry_q,
        .finished_output_q, .grant_alloc_q, .terminate_thread_q, .fixed_unit_thread_tag_q,
        .stream_out_prims_written_stat_q, .clipper_invocation_stat_q,
        .vertex0_primitive_type_q, .vertex0_first_flag_q, .vertex0_last_flag_q,
        .entry_tag_ch0_q, .result_handle_ch0_q, .entry_tag_ch1_q, .result_handle_ch1_q,
        .error_q, .error_cause_q
    );
    thread_sender sender (
        .mclk, .msg_valid, .desc_ctl, .ctl_bits, .hdr_dw0, .hdr_dw1, .hdr_dw2, .hdr_dw5
    );

    // 50 MHz clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Hang guard; the run needs well under a thousand cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("compares %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; a dead slave is caught by the hang guard, not here
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Send one message and judge every decoded output against our own reckoning
    task automatic send_chk(input logic [11:0] ctl, input logic [3:0] b, input logic [31:0] d2);
        logic [3:0] opc;
        logic [2:0] cz;
        logic ok, il;
        logic [31:0] d0, d1, d5;
        opc = ctl[3:0];
        il = ctl[11:10] == 2'h1;
        d0 = 32'h5a00_c300 ^ 32'(msg_n);
        d1 = ~d0;
        d5 = 32'hffff_ff00 | 32'(msg_n * 7);
        msg_n++;
        // Refusal priority: opcode, layout, bit combination, transposed offset
        if (opc > 4'h1) cz = 3'h1;
        else if (opc == 4'h0 && ctl[11:10] == 2'h3) cz = 3'h2;
        else if (b[1] && b[0]) cz = 3'h3;
        else if (opc == 4'h0 && ctl[11:10] == 2'h2 && ctl[4]) cz = 3'h4;
        else cz = 3'h0;
        ok = cz == 3'h0;
        sender.send({ctl, b, d0, d1, d2, d5});
        #1;
        chk("op", {out_valid_q, buffer_write_op_q, fixed_function_sync_op_q,
            ch1_valid_q, error_q, error_cause_q}, {1'b1, ok && opc == 4'h0, ok && opc == 4'h1,
            ok && opc == 4'h0 && il, !ok, cz});
        chk("action", {partial_write_q, release_entry_q, finished_output_q,
            grant_alloc_q, terminate_thread_q}, ok ? {!b[3] && !b[1] && !b[0], b[3] && !b[2],
            b[3] && b[2], b[1] && !b[0], b[0] && !b[1]} : 5'h00);
        chk("offset", {layout_q, offset_ch0_q, offset_ch1_q},
            {ctl[11:4], il ? ctl[9:4] : 6'h00});
        chk("chan0", {entry_tag_ch0_q, result_handle_ch0_q}, d0);
        chk("chan1", {entry_tag_ch1_q, result_handle_ch1_q}, il ? d1 : 32'h0);
        chk("header", {fixed_unit_thread_tag_q, vertex0_primitive_type_q,
            vertex0_first_flag_q, vertex0_last_flag_q}, {d5[7:0], d2[6:0]});
        chk("stats", {stream_out_prims_written_stat_q, clipper_invocation_stat_q},
            {ok && ctrl_sh[0] ? d2[26:16] : 11'h000, ok && d2[7] && ctrl_sh[1] && ctrl_sh[2]});
        @(posedge mclk);
        #1;
        chk("pulse", {out_valid_q, error_q, partial_write_q, release_entry_q,
            finished_output_q, grant_alloc_q, terminate_thread_q}, 32'h0);
    endtask

    // Reset values, control round trip and an unmapped word
    task automatic t_regs();
        chk("msg_ready", msg_ready, 32'h1);
        chk("reset outputs", {out_valid_q, error_q, layout_q, offset_ch0_q, entry_tag_ch0_q}, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk("count reset", rd, 32'h0);
        apb(1'b1, 12'h000, 32'h0000_0007);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl", rd, 32'h7);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b0, 12'h00c, 32'h0);
        chk("unmapped", {perr, rd[30:0]}, 32'h8000_0000);
    endtask

    // Every opcode, every layout with both offset parities, every control combination
    task automatic t_decode();
        for (int i = 0; i < 16; i++) begin
            send_chk({2'h0, 6'h07, 4'(i)}, 4'hc, 32'h0);
        end
        for (int l = 0; l < 8; l++) begin
            send_chk({2'(l >> 1), l[0] ? 6'h15 : 6'h2a, 4'h0}, 4'h0, 32'h0);
        end
        send_chk(12'hc11, 4'h8, 32'h0);
        for (int b = 0; b < 16; b++) begin
            send_chk(12'h010, 4'(b), 32'h0);
            send_chk(12'h011, 4'(b), 32'h0);
        end
    endtask

    // Header fields and statistic gating under five of the eight control settings
    task automatic t_header();
        for (int k = 0; k < 5; k++) begin
            ctrl_sh = 3'(k * 3);
            apb(1'b1, 12'h000, {29'h0, ctrl_sh});
            send_chk(12'h400, 4'h8, 32'h0555_00ab);
            send_chk(12'h400, 4'h3, 32'h02aa_00d4);
        end
    endtask

    // Message count and sticky error status with its clear
    task automatic t_status();
        apb(1'b1, 12'h008, 32'h0);
        send_chk(12'h00f, 4'h0, 32'h0);
        send_chk(12'h010, 4'hc, 32'h0);
        send_chk(12'h810, 4'h8, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk("count", rd[15:0], 32'h3);
        apb(1'b0, 12'h004, 32'h0);
        chk("status", rd & 32'h71, 32'h41);
        apb(1'b1, 12'h004, 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        chk("status clear", rd[0], 32'h0);
    endtask

    // Mid-run reset must clear control, count and the decoded outputs
    task automatic t_reset();
        @(posedge mclk);
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        ctrl_sh = 3'h0;
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl after reset", rd, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk("count after reset", rd, 32'h0);
        chk("outputs after reset", {buffer_write_op_q, layout_q, offset_ch0_q, entry_tag_ch0_q}, 32'h0);
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        ctrl_sh = 3'h0;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_decode();
        t_header();
        t_status();
        t_reset();
        wrap_up();
    end
endmodule
